// *** hw/dmac_pkg.sv ***
// Package: register map, field layout, reset values and carrier types
package dmac_pkg;

	localparam int DMAC_CHANNELS = 4;
	localparam int DMAC_CHAN_W = 2;
	localparam int DMAC_ADDR_W = 8;
	localparam int DMAC_BUS_W = 32;
	localparam int DMAC_PADR_W = 16;
	localparam int DMAC_CNT_W = 14;
	localparam int DMAC_LAST_W = 4;
	localparam int DMAC_DATA_W = 16;
	localparam int DMAC_FIFO_DEPTH = 8;

	// Register offsets (byte addresses)
	localparam logic [7:0] DMAC_OFS_PADR = 8'h00;
	localparam logic [7:0] DMAC_OFS_CNT = 8'h04;
	localparam logic [7:0] DMAC_OFS_CTRL = 8'h08;
	localparam logic [7:0] DMAC_OFS_LAST = 8'h40;
	localparam logic [7:0] DMAC_CH_SPAN = 8'h40;
	localparam logic [7:0] DMAC_OFS_MASK = 8'h0f;
	localparam int DMAC_CH_LSB = 4;

	// Control register fields
	localparam int DMAC_CTRL_EN_BIT = 0;
	localparam int DMAC_CTRL_DONE_BIT = 1;

	// Reset values
	localparam logic [15:0] DMAC_PADR_RST = 16'h0000;
	localparam logic [13:0] DMAC_CNT_RST = 14'h0000;
	localparam logic [3:0] DMAC_LAST_RST = 4'hf;

	typedef struct packed {
		logic [DMAC_CHAN_W-1:0] chan;
		logic [DMAC_DATA_W-1:0] data;
	} dmac_word_type;

	typedef struct packed {
		logic [DMAC_PADR_W-1:0] addr;
		logic [DMAC_DATA_W-1:0] data;
		logic [DMAC_CHAN_W-1:0] chan;
	} dmac_xfer_type;

	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} dmac_state_type;

endpackage : dmac_pkg

// *** hw/dmac_channel_slice.sv ***
// DMA channel address, count and last-channel registers with data FIFO
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Data FIFO
module dmac_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic inValid,
	input wire logic [WIDTH-1:0] inData,
	output logic inReady,
	// Drain side
	output logic outValid,
	output logic [WIDTH-1:0] outData,
	input wire logic outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [CW-1:0] count_r, count_nxt;
	logic inReady_r, inReady_nxt;
	logic push, pop;

	assign inReady = inReady_r;
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];

	always_comb begin
		push = inValid && inReady_r;
		pop = outValid && outReady;
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (push) begin
			wrPtr_nxt = (wrPtr_r == LAST_PTR) ? '0 : PW'(wrPtr_r + 1'b1);
		end
		if (pop) begin
			rdPtr_nxt = (rdPtr_r == LAST_PTR) ? '0 : PW'(rdPtr_r + 1'b1);
		end
		if (push && !pop) begin
			count_nxt = CW'(count_r + 1'b1);
		end else if (pop && !push) begin
			count_nxt = CW'(count_r - 1'b1);
		end
		inReady_nxt = (count_nxt != FULL_CNT);
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			inReady_r <= 1'b1;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
			inReady_r <= inReady_nxt;
		end
	end
endmodule : dmac_fifo

////////////////////////////////////////////////////////////////////////////////
// Channel register slice and transfer engine
// Behaviour
// - Per-channel 16-bit RW peripheral address, reset zero
// - 14-bit RW count, upper two bits read zero
// - Channel performs count plus one transfers
// - Last channel field codes channels 0 to 3
// - Last channel read-only, resets 1111, updated per transfer
// - Status bits fifteen to four read zero
module dmac_channel_slice
	import dmac_pkg::*;
#(
	parameter int CHANNELS = DMAC_CHANNELS,
	parameter int FIFO_DEPTH = DMAC_FIFO_DEPTH
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Avalon-MM slave
	input wire logic [DMAC_ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [DMAC_BUS_W-1:0] avsWriteData,
	input wire logic [3:0] avsByteEnable,
	output logic [DMAC_BUS_W-1:0] avsReadData,
	output logic avsWaitRequest,
	// Peripheral data in
	input wire logic srcValid,
	input wire dmac_word_type srcWord,
	output logic srcReady,
	// Transfers out
	output logic xferValid,
	output dmac_xfer_type xferWord,
	input wire logic xferReady,
	// Channel status
	output logic [CHANNELS-1:0] chanEnabled,
	output logic [CHANNELS-1:0] chanDone
);

	////////////////////////////////////////////////////////////////////////////
	// Address decode
	function automatic logic isChanReg(input logic [DMAC_ADDR_W-1:0] a);
		isChanReg = (a < DMAC_CH_SPAN) && ((a & DMAC_OFS_MASK) != 8'h0c);
	endfunction : isChanReg

	function automatic logic [DMAC_CHAN_W-1:0] regChan(
		input logic [DMAC_ADDR_W-1:0] a);
		regChan = a[DMAC_CH_LSB +: DMAC_CHAN_W];
	endfunction : regChan

	function automatic logic [15:0] mergeLow(input logic [15:0] old,
		input logic [DMAC_BUS_W-1:0] wd, input logic [3:0] be);
		mergeLow = old;
		if (be[0]) begin
			mergeLow[7:0] = wd[7:0];
		end
		if (be[1]) begin
			mergeLow[15:8] = wd[15:8];
		end
	endfunction : mergeLow

	////////////////////////////////////////////////////////////////////////////
	// State
	logic [DMAC_PADR_W-1:0] padr_r [CHANNELS];
	logic [DMAC_PADR_W-1:0] padr_nxt [CHANNELS];
	logic [DMAC_CNT_W-1:0] cnt_r [CHANNELS];
	logic [DMAC_CNT_W-1:0] cnt_nxt [CHANNELS];
	logic [DMAC_CNT_W-1:0] doneCnt_r [CHANNELS];
	logic [DMAC_CNT_W-1:0] doneCnt_nxt [CHANNELS];
	logic [CHANNELS-1:0] en_r, en_nxt, done_r, done_nxt;
	logic [DMAC_LAST_W-1:0] last_r, last_nxt;
	logic waitReq_r, waitReq_nxt;
	logic [DMAC_BUS_W-1:0] rdData_r, rdData_nxt;
	dmac_state_type state_r, state_nxt;
	logic xferValid_r, xferValid_nxt;
	dmac_xfer_type xfer_r, xfer_nxt;
	logic fifoOutValid, fifoPop;
	dmac_word_type fifoOut;
	logic [$bits(dmac_word_type)-1:0] fifoOutBits;

	assign fifoOut = dmac_word_type'(fifoOutBits);
	assign avsWaitRequest = waitReq_r;
	assign avsReadData = rdData_r;
	assign xferValid = xferValid_r;
	assign xferWord = xfer_r;
	assign chanEnabled = en_r;
	assign chanDone = done_r;

	////////////////////////////////////////////////////////////////////////////
	// Data FIFO
	dmac_fifo #(
		.WIDTH($bits(dmac_word_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(srcValid),
		.inData(srcWord),
		.inReady(srcReady),
		.outValid(fifoOutValid),
		.outData(fifoOutBits),
		.outReady(fifoPop)
	);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		logic access;
		logic commit;
		logic [DMAC_CHAN_W-1:0] ch;
		logic [DMAC_CHAN_W-1:0] wch;
		logic [7:0] ofs;
		logic finish;
		access = 1'b0;
		commit = 1'b0;
		ch = '0;
		wch = '0;
		ofs = '0;
		finish = 1'b0;
		padr_nxt = padr_r;
		cnt_nxt = cnt_r;
		doneCnt_nxt = doneCnt_r;
		en_nxt = en_r;
		done_nxt = done_r;
		last_nxt = last_r;
		waitReq_nxt = waitReq_r;
		rdData_nxt = rdData_r;
		state_nxt = state_r;
		xferValid_nxt = xferValid_r;
		xfer_nxt = xfer_r;
		fifoPop = 1'b0;

		// Bus: one wait cycle, then answer
		access = (avsRead || avsWrite) && waitReq_r;
		commit = avsWrite && !waitReq_r;
		waitReq_nxt = !access;
		wch = regChan(avsAddress);
		ofs = avsAddress & DMAC_OFS_MASK;
		if (access && avsRead) begin
			rdData_nxt = '0;
			if (isChanReg(avsAddress)) begin
				unique case (ofs)
					DMAC_OFS_PADR: rdData_nxt[15:0] = padr_r[wch];
					DMAC_OFS_CNT: rdData_nxt[DMAC_CNT_W-1:0] = cnt_r[wch];
					DMAC_OFS_CTRL: begin
						rdData_nxt[DMAC_CTRL_EN_BIT] = en_r[wch];
						rdData_nxt[DMAC_CTRL_DONE_BIT] = done_r[wch];
					end
					// Unaligned offsets read zero
					default: begin
					end
				endcase
			end else if (avsAddress == DMAC_OFS_LAST) begin
				rdData_nxt[DMAC_LAST_W-1:0] = last_r;
			end
		end

		// Transfer engine
		unique case (state_r)
			ST_IDLE: begin
				if (fifoOutValid) begin
					fifoPop = 1'b1;
					if (en_r[fifoOut.chan]) begin
						xfer_nxt.addr = padr_r[fifoOut.chan];
						xfer_nxt.data = fifoOut.data;
						xfer_nxt.chan = fifoOut.chan;
						xferValid_nxt = 1'b1;
						state_nxt = ST_BUSY;
					end
				end
			end
			ST_BUSY: begin
				if (xferReady) begin
					ch = xfer_r.chan;
					xferValid_nxt = 1'b0;
					state_nxt = ST_IDLE;
					last_nxt = DMAC_LAST_W'(ch);
					finish = (doneCnt_r[ch] == cnt_r[ch]);
					if (finish) begin
						doneCnt_nxt[ch] = '0;
						en_nxt[ch] = 1'b0;
					end else begin
						doneCnt_nxt[ch] = DMAC_CNT_W'(doneCnt_r[ch] + 1'b1);
					end
				end
			end
		endcase

		// Software writes
		if (commit && isChanReg(avsAddress)) begin
			unique case (ofs)
				DMAC_OFS_PADR:
					padr_nxt[wch] = mergeLow(padr_r[wch], avsWriteData,
						avsByteEnable);
				DMAC_OFS_CNT:
					cnt_nxt[wch] = DMAC_CNT_W'(mergeLow(16'(cnt_r[wch]),
						avsWriteData, avsByteEnable));
				DMAC_OFS_CTRL: begin
					if (avsByteEnable[0]) begin
						en_nxt[wch] = avsWriteData[DMAC_CTRL_EN_BIT];
						if (avsWriteData[DMAC_CTRL_EN_BIT] && !en_r[wch]) begin
							doneCnt_nxt[wch] = '0;
						end
						if (avsWriteData[DMAC_CTRL_DONE_BIT]) begin
							done_nxt[wch] = 1'b0;
						end
					end
				end
				// Unaligned offsets ignored
				default: begin
				end
			endcase
		end
		// Done set wins over clear
		if (finish) begin
			done_nxt[ch] = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHANNELS; i++) begin
				padr_r[i] <= DMAC_PADR_RST;
				cnt_r[i] <= DMAC_CNT_RST;
				doneCnt_r[i] <= '0;
			end
			en_r <= '0;
			done_r <= '0;
			last_r <= DMAC_LAST_RST;
			waitReq_r <= 1'b1;
			rdData_r <= '0;
			state_r <= ST_IDLE;
			xferValid_r <= 1'b0;
			xfer_r <= '0;
		end else begin
			padr_r <= padr_nxt;
			cnt_r <= cnt_nxt;
			doneCnt_r <= doneCnt_nxt;
			en_r <= en_nxt;
			done_r <= done_nxt;
			last_r <= last_nxt;
			waitReq_r <= waitReq_nxt;
			rdData_r <= rdData_nxt;
			state_r <= state_nxt;
			xferValid_r <= xferValid_nxt;
			xfer_r <= xfer_nxt;
		end
	end
endmodule : dmac_channel_slice

`default_nettype wire

// *** testbench/dmac_slice_asserts.sv ***
// Port checker for the DMA channel slice
`timescale 1ns/1ps
`default_nettype none
module dmac_slice_asserts
	import dmac_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clock, reset and bus
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [DMAC_ADDR_W-1:0] avsAddress,
	input wire logic avsRead,
	input wire logic avsWrite,
	input wire logic [DMAC_BUS_W-1:0] avsReadData,
	input wire logic avsWaitRequest,
	// Transfers and status
	input wire logic xferValid,
	input wire dmac_xfer_type xferWord,
	input wire logic xferReady,
	input wire logic [CHANNELS-1:0] chanEnabled,
	input wire logic [CHANNELS-1:0] chanDone
);
	logic [3:0] lastR;
	wire logic hs = xferValid && xferReady;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			lastR <= DMAC_LAST_RST;
		else if (hs)
			lastR <= {2'h0, xferWord.chan};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_req; (avsRead || avsWrite) && avsWaitRequest; endsequence
	sequence s_rd; avsRead && !avsWaitRequest; endsequence
	property p_ans; s_req |=> !avsWaitRequest; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_rel; !avsWaitRequest |=> avsWaitRequest; endproperty
	a_rel: assert property (p_rel) else $error("long answer");
	property p_cnt;
		s_rd ##0 (avsAddress < 8'h40 && avsAddress[3:0] == 4'h4)
			|-> avsReadData[31:14] == 18'h0;
	endproperty
	a_cnt: assert property (p_cnt) else $error("count top bits");
	property p_hi; s_rd ##0 avsAddress == 8'h40 |-> avsReadData[31:4] == 28'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("status top bits");
	property p_last;
		s_rd ##0 avsAddress == 8'h40 |-> avsReadData[3:0] == $past(lastR);
	endproperty
	a_last: assert property (p_last) else $error("last channel");
	property p_hold; xferValid && !xferReady |=> xferValid && $stable(xferWord);
	endproperty
	a_hold: assert property (p_hold) else $error("transfer dropped");
	property p_gap; hs |=> !xferValid; endproperty
	a_gap: assert property (p_gap) else $error("transfer gap");
	property p_done;
		(chanDone & ~$past(chanDone)) != '0 |-> $past(hs)
			&& (chanEnabled & chanDone & ~$past(chanDone)) == '0;
	endproperty
	a_done: assert property (p_done) else $error("done without end");
endmodule : dmac_slice_asserts
bind dmac_channel_slice dmac_slice_asserts #(.CHANNELS(CHANNELS)) chk_inst (
	.clk(clk), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
	.avsWrite(avsWrite), .avsReadData(avsReadData),
	.avsWaitRequest(avsWaitRequest), .xferValid(xferValid),
	.xferWord(xferWord), .xferReady(xferReady),
	.chanEnabled(chanEnabled), .chanDone(chanDone));
`default_nettype wire

// *** testbench/dmac_sink_model.sv ***
// Transfer sink: prompt, slow or stalled
`timescale 1ns/1ps
`default_nettype none
module dmac_sink_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Handshake and pace (0 prompt, 1 slow, 2 stalled)
	input wire logic xferValid,
	input wire logic [1:0] pace,
	output logic xferReady
);
	logic [1:0] tick;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick <= 2'h0;
			xferReady <= 1'b0;
		end else begin
			tick <= tick + 2'h1;
			xferReady <= xferValid && (pace == 2'h0 || (pace == 2'h1 && tick == 2'h3));
		end
	end
endmodule : dmac_sink_model
`default_nettype wire

// *** testbench/test_dmac_channel_slice.sv ***
// Bench for the DMA channel slice
`timescale 1ns/1ps
`default_nettype none
module test_dmac_channel_slice
	import dmac_pkg::*;
();
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] avsAddress = 8'h00;
	logic avsRead = 1'b0;
	logic avsWrite = 1'b0;
	logic [31:0] avsWriteData = 32'h0;
	logic [31:0] avsReadData;
	logic avsWaitRequest, srcValid = 1'b0, srcReady, xferValid, xferReady;
	dmac_word_type srcWord = '0;
	dmac_xfer_type xferWord;
	logic [3:0] chanEnabled, chanDone;
	logic [1:0] pace = 2'h0, curCh = 2'h0;
	int n_errors = 0, compares = 0, nXf = 0, nPush = 0, cyc = 0;
	always #50 clk = ~clk;
	dmac_channel_slice dmac_channel_slice_inst (.clk(clk), .rst_n(rst_n),
		.avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
		.avsWriteData(avsWriteData), .avsByteEnable(4'hf),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
		.srcValid(srcValid), .srcWord(srcWord), .srcReady(srcReady),
		.xferValid(xferValid), .xferWord(xferWord), .xferReady(xferReady),
		.chanEnabled(chanEnabled), .chanDone(chanDone));
	dmac_sink_model dmac_sink_model_inst (.clk(clk), .rst_n(rst_n),
		.xferValid(xferValid), .pace(pace), .xferReady(xferReady));
	task automatic chk(string nm, logic [33:0] e, logic [33:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task print_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	task bus(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
		logic w;
		avsAddress <= a;
		avsWriteData <= d;
		avsRead <= !wr;
		avsWrite <= wr;
		do begin
			@(posedge clk);
			w = avsWaitRequest;
			q = avsReadData;
		end while (w);
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		@(posedge clk);
	endtask : bus
	task rdc(string nm, logic [7:0] a, logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, {2'h0, e}, {2'h0, q});
	endtask : rdc
	task push(int tries, output logic ok);
		srcWord <= {curCh, 16'(nPush)};
		srcValid <= 1'b1;
		ok = 1'b0;
		repeat (tries) begin
			@(posedge clk);
			ok = srcReady;
			if (ok) break;
		end
		srcValid <= 1'b0;
		nPush += int'(ok);
		@(posedge clk);
	endtask : push
	task waitXf(int t);
		repeat (300) if (nXf < t) @(posedge clk);
	endtask : waitXf
	always @(posedge clk) begin
		cyc++;
		if (rst_n && xferValid && xferReady) begin
			chk("xfer", {16'ha5c0 + 16'(curCh), 16'(nXf), curCh}, xferWord);
			nXf++;
		end
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	initial begin
		logic ok;
		logic [31:0] q;
		int i;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc("last", 8'h40, 32'hf);
		bus(1'b1, 8'h40, 32'h0, q);
		rdc("last", 8'h40, 32'hf);
		rdc("hole", 8'h0c, 32'h0);
		for (i = 0; i < 4; i++) begin
			rdc("padr", 8'(i * 16), 32'h0);
			rdc("cnt", 8'(i * 16 + 4), 32'h0);
			bus(1'b1, 8'(i * 16), 32'hffffa5c0 + i, q);
			bus(1'b1, 8'(i * 16 + 4), 32'hffffffff, q);
			rdc("padr", 8'(i * 16), 32'ha5c0 + i);
			rdc("cnt", 8'(i * 16 + 4), 32'h3fff);
		end
		for (i = 0; i < 4; i++) begin
			curCh = 2'(i);
			pace <= 2'(i % 2);
			bus(1'b1, 8'(i * 16 + 4), 32'(i), q);
			bus(1'b1, 8'(i * 16 + 8), 32'h1, q);
			repeat (i + 1) push(50, ok);
			waitXf(nPush);
			rdc("ctrl", 8'(i * 16 + 8), 32'h2);
			rdc("last", 8'h40, 32'(i));
			chk("done", 34'((1 << (i + 1)) - 1), 34'(chanDone));
			chk("en", 34'h0, 34'(chanEnabled));
		end
		push(50, ok);
		repeat (20) @(posedge clk);
		chk("drop", 34'(nPush - 1), 34'(nXf));
		nPush--;
		curCh = 2'h0;
		pace <= 2'h2;
		bus(1'b1, 8'h04, 32'h9, q);
		bus(1'b1, 8'h08, 32'h3, q);
		rdc("ctrl", 8'h08, 32'h1);
		i = nPush;
		do push(3, ok); while (ok && nPush - i < 20);
		chk("fill", 34'h9, 34'(nPush - i));
		pace <= 2'h1;
		push(50, ok);
		waitXf(nPush);
		chk("count", 34'(i + 10), 34'(nXf));
		rdc("ctrl", 8'h08, 32'h2);
		chk("done", 34'hf, 34'(chanDone));
		chk("en", 34'h0, 34'(chanEnabled));
		print_verdict();
	end
endmodule : test_dmac_channel_slice
`default_nettype wire
